/* cmp_filter_pkg.sv */
// Package holding register offsets, field layouts, reset values and counts of the comparator sample filter.
package cmp_filter_pkg;

    // Register byte offsets on the APB bus.
    localparam logic [7:0] control_zero_offset   = 8'h00;
    localparam logic [7:0] period_offset         = 8'h04;
    localparam logic [7:0] control_one_offset    = 8'h08;
    localparam logic [7:0] status_control_offset = 8'h0c;

    // Field widths and positions.
    localparam int count_width  = 3;
    localparam int period_width = 8;
    localparam int en_bit       = 0;
    localparam int we_bit       = 1;
    localparam int se_bit       = 2;
    localparam int rise_flag_bit   = 0;
    localparam int fall_flag_bit   = 1;
    localparam int rise_enable_bit = 2;
    localparam int fall_enable_bit = 3;
    localparam int filtered_bit    = 4;
    localparam int raw_bit         = 5;

    // Reset values.
    localparam logic [2:0] count_reset  = 3'h0;
    localparam logic [7:0] period_reset = 8'h00;
    localparam logic [2:0] ctrl1_reset  = 3'h0;

    // Highest count that still means plain resampling; filtering acts only above it.
    localparam logic [2:0] single_sample = 3'h1;

    // Stages of every synchroniser.
    localparam int sync_stages = 2;

endpackage

/* sync_bit.sv */
// Two flip-flop synchroniser for a single level.
`timescale 1ns/10ps
module sync_bit
    import cmp_filter_pkg::*;
(
    input  wire logic clock,
    input  wire logic nrst,
    input  wire logic d,
    output logic      q
);
    logic meta;
    logic next_meta;
    logic next_q;

    // The first stage feeds only the second; nothing else reads it.
    always_comb begin
        next_meta = d;
        next_q    = meta;
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            meta <= 1'b0;
            q    <= 1'b0;
        end else begin
            meta <= next_meta;
            q    <= next_q;
        end
    end
endmodule

/* edge_detect.sv */
// Rising and falling edge detector for a synchronised level.
`timescale 1ns/10ps
module edge_detect (
    input  wire logic clock,
    input  wire logic nrst,
    input  wire logic level,
    output logic      rise,
    output logic      fall
);
    logic last;
    logic next_last;

    // Compare the level with its value one cycle ago.
    always_comb begin
        next_last = level;
        rise      = level & ~last;
        fall      = ~level & last;
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            last <= 1'b0;
        end else begin
            last <= next_last;
        end
    end
endmodule

/* comparator_sample_filter.sv */
// Sampling, windowing and consecutive-sample filter for a comparator output, with APB registers.
`timescale 1ns/10ps
// Function
// - Filtering acts only when the count exceeds one and either the period or the sample enable is set.
// - From the bus clock, a sample is taken every period-field bus clock cycles.
// - The filtered output starts at zero and moves only after count consecutive agreeing samples.
// - With sample enable and period both zero the filter stops and clears its counters and filter state, but held_raw keeps its value.
// - With sample enable set, a sample is taken on each rising edge of the external sample input.
// - A disagreeing sample restarts the consecutive count.
// - Windowed with count one and a period resamples the windowed output unfiltered.
// - Windowed with count above one and a period windows and then filters.
// - An interrupt may be raised on rising, falling or both edges of the output.
// - The interrupt is asserted while the rise enable and rise flag are both set.
// - The interrupt is asserted while the fall enable and fall flag are both set.
// - The interrupt drops once the enable or the flag of each active edge is cleared.
// - In windowed modes the raw latch follows the comparator while the window is high and holds otherwise.
// - Edge flags always come from synchronisation and edge detection; the sampled output comes from the same synchroniser.
module comparator_sample_filter
    import cmp_filter_pkg::*;
#(
    parameter int cnt_w = count_width,
    parameter int per_w = period_width
)
(
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        raw_compare_out,
    input  wire logic        window,
    input  wire logic        sample_in,
    output logic             filtered_compare_out,
    output logic             irq
);
    // Software registers.
    logic [cnt_w-1:0] consecutive_sample_count;
    logic [per_w-1:0] sample_period_field;
    logic             enable;
    logic             window_enable;
    logic             external_sample_enable;
    logic             rise_irq_enable;
    logic             fall_irq_enable;
    logic             rise_edge_flag;
    logic             fall_edge_flag;
    logic [cnt_w-1:0] next_consecutive_sample_count;
    logic [per_w-1:0] next_sample_period_field;
    logic             next_enable;
    logic             next_window_enable;
    logic             next_external_sample_enable;
    logic             next_rise_irq_enable;
    logic             next_fall_irq_enable;
    logic             next_rise_edge_flag;
    logic             next_fall_edge_flag;
    logic [31:0]      next_prdata;
    logic             next_pready;
    logic             next_pslverr;
    logic             next_irq;

    // Filter state.
    logic             held_raw;
    logic [per_w-1:0] period_count;
    logic [cnt_w-1:0] agree_count;
    logic             filter_state;
    logic             sample_prev;
    logic             next_held_raw;
    logic [per_w-1:0] next_period_count;
    logic [cnt_w-1:0] next_agree_count;
    logic             next_filter_state;
    logic             next_sample_prev;
    logic             next_filtered;

    // Synchronised inputs and edges.
    logic raw_sync;
    logic window_sync;
    logic sample_sync;
    logic out_sync;
    logic out_rise;
    logic out_fall;

    // Mode decode.
    logic sampled_mode;
    logic filter_on;
    logic sample_tick;
    logic pick_raw;
    logic out_level;

    logic access;
    logic wr;
    logic rd;

    // Every pin input passes two flip-flops before use.
    sync_bit u_sync_raw (
        .clock (clock),
        .nrst  (nrst),
        .d     (raw_compare_out),
        .q     (raw_sync)
    );
    sync_bit u_sync_win (
        .clock (clock),
        .nrst  (nrst),
        .d     (window),
        .q     (window_sync)
    );
    sync_bit u_sync_smp (
        .clock (clock),
        .nrst  (nrst),
        .d     (sample_in),
        .q     (sample_sync)
    );

    // Output synchronised once more before edge detection, so flags never see a glitch.
    sync_bit u_sync_out (
        .clock (clock),
        .nrst  (nrst),
        .d     (out_level),
        .q     (out_sync)
    );
    edge_detect u_edges (
        .clock (clock),
        .nrst  (nrst),
        .level (out_sync),
        .rise  (out_rise),
        .fall  (out_fall)
    );

    // Mode decode and sample strobe.
    always_comb begin
        sampled_mode = external_sample_enable || (sample_period_field != '0);
        filter_on    = enable && sampled_mode;
        // Count of one or below is plain resampling; above one is real filtering.
        pick_raw     = window_enable ? held_raw : raw_sync;
        // Flags follow whatever the output shows, so continuous modes raise edges as well.
        out_level    = filter_on ? filter_state : (enable && pick_raw);
        if (external_sample_enable) begin
            sample_tick = sample_sync & ~sample_prev;
        end else begin
            sample_tick = (period_count == sample_period_field - 1'b1);
        end
    end

    // Window latch, period counter and consecutive-sample filter.
    always_comb begin
        next_held_raw     = held_raw;
        next_period_count = period_count;
        next_agree_count  = agree_count;
        next_filter_state = filter_state;
        next_sample_prev  = sample_sync;
        if (window_sync) begin
            next_held_raw = raw_sync;
        end
        if (!filter_on) begin
            // Disabled setting clears the counters, filter state and sample_prev but not held_raw, which is also how a reprogram starts clean.
            next_period_count = '0;
            next_agree_count  = '0;
            next_filter_state = 1'b0;
            next_sample_prev  = 1'b0;
        end else begin
            // The divider runs only for the internal timebase; an external strobe needs no count.
            if (!external_sample_enable) begin
                next_period_count = sample_tick ? '0 : period_count + 1'b1;
            end
            // Each sample either matches the output, which restarts the vote, or adds one vote.
            if (sample_tick) begin
                if (consecutive_sample_count <= single_sample) begin
                    next_filter_state = pick_raw;
                    next_agree_count  = '0;
                end else if (pick_raw == filter_state) begin
                    next_agree_count  = '0;
                end else if (agree_count + 1'b1 >= consecutive_sample_count) begin
                    next_filter_state = pick_raw;
                    next_agree_count  = '0;
                end else begin
                    next_agree_count  = agree_count + 1'b1;
                end
            end
        end
        // Continuous modes pass the synchronised comparator, or held_raw when windowed, straight to the output.
        next_filtered = filter_on ? out_sync : pick_raw;
        if (!enable) begin
            next_filtered = 1'b0;
        end
    end

    // APB decode, register writes, sticky flags and interrupt.
    always_comb begin
        // An access is taken once: pready answers in the next cycle and blocks a second take.
        access = psel && penable && !pready;
        wr     = access && pwrite;
        rd     = access && !pwrite;
        next_consecutive_sample_count = consecutive_sample_count;
        next_sample_period_field      = sample_period_field;
        next_enable                   = enable;
        next_window_enable            = window_enable;
        next_external_sample_enable   = external_sample_enable;
        next_rise_irq_enable          = rise_irq_enable;
        next_fall_irq_enable          = fall_irq_enable;
        next_rise_edge_flag           = rise_edge_flag;
        next_fall_edge_flag           = fall_edge_flag;
        next_pready                   = access;
        next_pslverr                  = 1'b0;
        next_prdata                   = 32'h0000_0000;
        // A write to an unknown offset changes nothing and answers with an error.
        if (wr) begin
            case (paddr)
                control_zero_offset: begin
                    next_consecutive_sample_count = pwdata[cnt_w-1:0];
                end
                period_offset: begin
                    next_sample_period_field = pwdata[per_w-1:0];
                end
                control_one_offset: begin
                    next_enable                 = pwdata[en_bit];
                    next_window_enable          = pwdata[we_bit];
                    next_external_sample_enable = pwdata[se_bit];
                end
                status_control_offset: begin
                    next_rise_irq_enable = pwdata[rise_enable_bit];
                    next_fall_irq_enable = pwdata[fall_enable_bit];
                    if (pwdata[rise_flag_bit]) next_rise_edge_flag = 1'b0;
                    if (pwdata[fall_flag_bit]) next_fall_edge_flag = 1'b0;
                end
                default: next_pslverr = 1'b1;
            endcase
        end
        // Reads return zero outside the defined fields, so software need not mask them.
        if (rd) begin
            case (paddr)
                control_zero_offset: next_prdata[cnt_w-1:0] = consecutive_sample_count;
                period_offset:       next_prdata[per_w-1:0] = sample_period_field;
                control_one_offset: begin
                    next_prdata[en_bit] = enable;
                    next_prdata[we_bit] = window_enable;
                    next_prdata[se_bit] = external_sample_enable;
                end
                status_control_offset: begin
                    next_prdata[rise_flag_bit]   = rise_edge_flag;
                    next_prdata[fall_flag_bit]   = fall_edge_flag;
                    next_prdata[rise_enable_bit] = rise_irq_enable;
                    next_prdata[fall_enable_bit] = fall_irq_enable;
                    next_prdata[filtered_bit]    = filtered_compare_out;
                    next_prdata[raw_bit]         = raw_sync;
                end
                default: next_pslverr = 1'b1;
            endcase
        end
        // Edge sets win over a clear in the same cycle.
        if (out_rise) next_rise_edge_flag = 1'b1;
        if (out_fall) next_fall_edge_flag = 1'b1;
        next_irq = (next_rise_irq_enable && next_rise_edge_flag) ||
                   (next_fall_irq_enable && next_fall_edge_flag);
    end

    // Every register of the block; the synchronous reset gives each output a known zero.
    always_ff @(posedge clock) begin
        if (!nrst) begin
            consecutive_sample_count <= cnt_w'(count_reset);
            sample_period_field      <= per_w'(period_reset);
            enable                   <= 1'b0;
            window_enable            <= 1'b0;
            external_sample_enable   <= 1'b0;
            rise_irq_enable          <= 1'b0;
            fall_irq_enable          <= 1'b0;
            rise_edge_flag           <= 1'b0;
            fall_edge_flag           <= 1'b0;
            prdata                   <= 32'h0000_0000;
            pready                   <= 1'b0;
            pslverr                  <= 1'b0;
            irq                      <= 1'b0;
            held_raw                 <= 1'b0;
            period_count             <= '0;
            agree_count              <= '0;
            filter_state             <= 1'b0;
            sample_prev              <= 1'b0;
            filtered_compare_out     <= 1'b0;
        end else begin
            consecutive_sample_count <= next_consecutive_sample_count;
            sample_period_field      <= next_sample_period_field;
            enable                   <= next_enable;
            window_enable            <= next_window_enable;
            external_sample_enable   <= next_external_sample_enable;
            rise_irq_enable          <= next_rise_irq_enable;
            fall_irq_enable          <= next_fall_irq_enable;
            rise_edge_flag           <= next_rise_edge_flag;
            fall_edge_flag           <= next_fall_edge_flag;
            prdata                   <= next_prdata;
            pready                   <= next_pready;
            pslverr                  <= next_pslverr;
            irq                      <= next_irq;
            held_raw                 <= next_held_raw;
            period_count             <= next_period_count;
            agree_count              <= next_agree_count;
            filter_state             <= next_filter_state;
            sample_prev              <= next_sample_prev;
            filtered_compare_out     <= next_filtered;
        end
    end
endmodule

/* comparator_sample_filter_checker.sv */
// Concurrent checks on the ports of the comparator sample filter.
`timescale 1ns/10ps
module comparator_sample_filter_checker
    import cmp_filter_pkg::*;
(
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        raw_compare_out,
    input wire logic        window,
    input wire logic        sample_in,
    input wire logic        filtered_compare_out,
    input wire logic        irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);

    // Completed writes to any register offset.
    logic wr_done;
    assign wr_done = psel && penable && pready && pwrite;

    property p_ready; psel && penable && !pready |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("pready did not follow the access phase");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("pready held longer than one cycle");
    property p_err; pslverr |-> pready && $past(psel && penable); endproperty
    a_err: assert property (p_err) else $error("pslverr outside a completed access");
    property p_rdata; !pready |-> prdata == 32'h0; endproperty
    a_rdata: assert property (p_rdata) else $error("prdata not zero outside pready");
    property p_reset; $rose(nrst) |-> !irq && !filtered_compare_out; endproperty
    a_reset: assert property (p_reset) else $error("outputs not zero after reset");
    property p_irq_drop;
        wr_done && paddr == status_control_offset && pwdata[3:2] == 2'b00 |=> ##1 !irq;
    endproperty
    a_irq_drop: assert property (p_irq_drop) else $error("irq stayed with enables off");
    property p_irq_fall; $fell(irq) |-> wr_done && paddr == status_control_offset;
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without a write");
    property p_off; wr_done && paddr == control_one_offset && !pwdata[0]
        |-> ##[1:8] !filtered_compare_out; endproperty
    a_off: assert property (p_off) else $error("output not cleared when disabled");

    c_irq: cover property ($rose(irq));
    c_out: cover property ($rose(filtered_compare_out));
    c_err: cover property (pslverr);
    c_win: cover property (window && filtered_compare_out);
    c_smp: cover property ($rose(sample_in) ##[1:8] $rose(filtered_compare_out));
endmodule

bind comparator_sample_filter comparator_sample_filter_checker u_chk (
    .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .raw_compare_out(raw_compare_out), .window(window), .sample_in(sample_in),
    .filtered_compare_out(filtered_compare_out), .irq(irq));

/* comparator_source.sv */
// Model of the analog comparator, window and sample sources, and the interrupt controller.
`timescale 1ns/10ps
module comparator_source (
    input  wire logic clock,
    input  wire logic irq,
    output logic      raw_compare_out,
    output logic      window,
    output logic      sample_in
);
    int   irq_rises = 0;
    logic irq_last  = 1'b0;

    initial begin
        raw_compare_out = 1'b0;
        window          = 1'b0;
        sample_in       = 1'b0;
    end

    task set_raw(input logic v);
        @(posedge clock);
        raw_compare_out <= v;
    endtask

    task set_window(input logic v);
        @(posedge clock);
        window <= v;
    endtask

    // Pulses are three cycles wide so the two-stage synchroniser cannot miss them.
    task pulse(input int n);
        repeat (n) begin
            @(posedge clock);
            sample_in <= 1'b1;
            repeat (3) @(posedge clock);
            sample_in <= 1'b0;
            repeat (2) @(posedge clock);
        end
    endtask

    // The interrupt controller counts each new request it sees.
    always @(posedge clock) begin
        irq_last <= irq;
        if (irq && !irq_last) begin
            irq_rises <= irq_rises + 1;
        end
    end
endmodule

/* test_comparator_sample_filter.sv */
// Self-checking bench for the comparator sample filter.
`timescale 1ns/10ps
module test_comparator_sample_filter;
    import cmp_filter_pkg::*;
    logic        clock;
    logic        nrst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        raw_compare_out;
    logic        window;
    logic        sample_in;
    logic        filtered_compare_out;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    int          error_cnt = 0;
    int          tests_run = 0;
    int          cycles = 0;

    comparator_sample_filter DUT (
        .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .raw_compare_out(raw_compare_out), .window(window),
        .sample_in(sample_in), .filtered_compare_out(filtered_compare_out), .irq(irq));

    comparator_source src (
        .clock(clock), .irq(irq), .raw_compare_out(raw_compare_out),
        .window(window), .sample_in(sample_in));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // A hung wait is cut off well after every scenario should have ended.
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            error_cnt = error_cnt + 1;
            results();
        end
    end

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task results();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // One APB transfer; the request is held until pready is sampled high.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 16);
        check("pready", pready, 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task wait_out(input logic v, input int lim);
        int n;
        n = 0;
        while (filtered_compare_out !== v && n < lim) begin
            @(posedge clock);
            n++;
        end
    endtask

    // Parameters change only from the disabled setting, so the filter starts clean.
    task cfg(input logic [2:0] c, input logic [7:0] p, input logic [2:0] m);
        apb(1'b1, control_one_offset, 32'h0);
        apb(1'b1, period_offset, 32'h0);
        apb(1'b1, control_zero_offset, {29'h0, c});
        apb(1'b1, period_offset, {24'h0, p});
        apb(1'b1, control_one_offset, {29'h0, m});
    endtask

    task t_regs();
        apb(1'b0, control_zero_offset, 32'h0);
        check("count_rst", rd, {29'h0, count_reset});
        apb(1'b0, control_one_offset, 32'h0);
        check("ctrl1_rst", rd, {29'h0, ctrl1_reset});
        apb(1'b0, status_control_offset, 32'h0);
        check("status_rst", rd, 32'h0);
        apb(1'b1, period_offset, 32'h0000_01a5);
        apb(1'b0, period_offset, 32'h0);
        check("period_rw", rd, 32'h0000_00a5);
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped_err", {31'h0, err}, 32'h1);
        check("unmapped_rd", rd, 32'h0);
    endtask

    // Count four, period four: a dip in mid-count must restart the latency.
    task t_filter();
        cfg(3'h4, 8'h04, 3'h1);
        apb(1'b1, status_control_offset, 32'h4);
        src.set_raw(1'b1);
        repeat (10) @(posedge clock);
        check("out_early", filtered_compare_out, 1'b0);
        src.set_raw(1'b0);
        repeat (5) @(posedge clock);
        src.set_raw(1'b1);
        repeat (10) @(posedge clock);
        check("out_restart", filtered_compare_out, 1'b0);
        wait_out(1'b1, 30);
        check("out_rise", filtered_compare_out, 1'b1);
        repeat (4) @(posedge clock);
        check("irq_rise", irq, 1'b1);
        apb(1'b0, status_control_offset, 32'h0);
        check("status_rise", rd[5:0], 6'h35);
        apb(1'b1, status_control_offset, 32'h5);
        repeat (3) @(posedge clock);
        check("irq_cleared", irq, 1'b0);
        apb(1'b1, status_control_offset, 32'h8);
        src.set_raw(1'b0);
        wait_out(1'b0, 30);
        repeat (4) @(posedge clock);
        check("irq_fall", irq, 1'b1);
        apb(1'b1, status_control_offset, 32'h2);
        repeat (3) @(posedge clock);
        check("irq_off", irq, 1'b0);
        check("irq_count", src.irq_rises, 32'h2);
    endtask

    task t_ext();
        cfg(3'h2, 8'h00, 3'h5);
        src.set_raw(1'b1);
        repeat (20) @(posedge clock);
        check("ext_idle", filtered_compare_out, 1'b0);
        src.pulse(2);
        wait_out(1'b1, 12);
        check("ext_rise", filtered_compare_out, 1'b1);
    endtask

    // Period and sample enable both zero leave the filter bypassed.
    task t_cont();
        cfg(3'h2, 8'h00, 3'h1);
        wait_out(1'b1, 8);
        check("cont_one", filtered_compare_out, 1'b1);
        apb(1'b1, status_control_offset, 32'h3);
        src.set_raw(1'b0);
        wait_out(1'b0, 8);
        check("cont_zero", filtered_compare_out, 1'b0);
        apb(1'b0, status_control_offset, 32'h0);
        check("cont_flags", rd[1:0], 2'h2);
    endtask

    task t_window();
        cfg(3'h1, 8'h02, 3'h3);
        src.set_raw(1'b1);
        repeat (16) @(posedge clock);
        check("win_hold", filtered_compare_out, 1'b0);
        src.set_window(1'b1);
        wait_out(1'b1, 12);
        check("win_resample", filtered_compare_out, 1'b1);
        src.set_window(1'b0);
        src.set_raw(1'b0);
        repeat (16) @(posedge clock);
        check("win_held", filtered_compare_out, 1'b1);
        cfg(3'h3, 8'h02, 3'h3);
        src.set_raw(1'b1);
        src.set_window(1'b1);
        wait_out(1'b1, 20);
        check("win_filter", filtered_compare_out, 1'b1);
    endtask

    initial begin
        nrst    = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0;
        repeat (3) @(posedge clock);
        nrst <= 1'b1;
        t_regs();
        t_filter();
        t_ext();
        t_cont();
        t_window();
        results();
    end
endmodule
